// [verilog/wwd_regs.svh]
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

// Byte addresses of the register words.
`define WWD_OFF_CMD    8'h00
`define WWD_OFF_STATUS 8'h04
`define WWD_OFF_ERR    8'h08
`define WWD_OFF_CAUSE  8'h0C
`define WWD_OFF_DATA   8'h10
`define WWD_OFF_USER   8'h14

// Reset values.
`define WWD_RST_USER   8'h02
`define WWD_RST_CAUSE  3'h1
`define WWD_RST_DATA   16'h0000

// Field positions.
`define WWD_ST_VARIANT 2
`define WWD_ST_BUSY    3
`define WWD_ST_DONE    4
`define WWD_ST_INVALID 7
`define WWD_CAUSE_POR  0
`define WWD_CAUSE_TOUT 1
`define WWD_CAUSE_VIOL 2
`define WWD_ERR_TRIG   0
`define WWD_ERR_SUPPLY 1

// Timing: clock rate, wake debounce time and cycle counts.
`define WWD_CLK_MHZ    25
`define WWD_DEB_NS     2000
`define WWD_DEB_CYC    ((`WWD_DEB_NS * `WWD_CLK_MHZ) / 1000)
`define WWD_INIT_CYC   50000
`define WWD_CLOSED_CYC 10000
`define WWD_OPEN_CYC   40000
`define WWD_MR_CYC     2500
`define WWD_START_CYC  5000
`define WWD_WSLP_CYC   5000
`define WWD_WSTBY_CYC  1000
`define WWD_MEAS_CYC   20000

`endif

// [verilog/wwd_pkg.sv]
`default_nettype none
package wwd_pkg;

  typedef enum logic [1:0] {
    MODE_NRM  = 2'b00,
    MODE_STBY = 2'b01,
    MODE_SLP  = 2'b10
  } wwd_mode_type;

  typedef enum logic [1:0] {
    WD_OFF    = 2'b00,
    WD_INIT   = 2'b01,
    WD_CLOSED = 2'b10,
    WD_OPEN   = 2'b11
  } wwd_wd_type;

  typedef enum logic [3:0] {
    CMD_NRM    = 4'h1,
    CMD_SLP_A  = 4'h2,
    CMD_SLP_B  = 4'h3,
    CMD_STBY_A = 4'h4,
    CMD_STBY_B = 4'h5,
    CMD_CR     = 4'h6,
    CMD_SM     = 4'h7,
    CMD_RO     = 4'h8,
    CMD_SMX    = 4'h9
  } wwd_cmd_type;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } wwd_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } wwd_axi_rsp_type;

endpackage
`default_nettype wire

// [verilog/wwd_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wwd_regs.svh"

module wwd_control
  import wwd_pkg::*;
#(
  parameter int unsigned CNT_W      = 20,
  parameter int unsigned INIT_CYC   = `WWD_INIT_CYC,
  parameter int unsigned CLOSED_CYC = `WWD_CLOSED_CYC,
  parameter int unsigned OPEN_CYC   = `WWD_OPEN_CYC,
  parameter int unsigned MR_CYC     = `WWD_MR_CYC,
  parameter int unsigned START_CYC  = `WWD_START_CYC,
  parameter int unsigned WSLP_CYC   = `WWD_WSLP_CYC,
  parameter int unsigned WSTBY_CYC  = `WWD_WSTBY_CYC,
  parameter int unsigned MEAS_CYC   = `WWD_MEAS_CYC
) (
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  input  wire logic            clkEn,
  input  wire wwd_axi_req_type axiReq,
  output var  wwd_axi_rsp_type axiRsp,
  input  wire logic            wdTrigger,
  input  wire logic            wakeUpN,
  input  wire logic            supplyFault,
  input  wire logic [15:0]     measSample,
  output var  logic            masterResetN,
  output var  logic            dataReady
);

  // Pin synchronisers and agreed levels.
  logic [2:0] trigSync;
  logic       trigLvl;
  logic [2:0] wakeSync;
  logic       wakeLvl;
  logic       wakeDeb;
  logic [7:0] debCnt;

  // Watchdog and master reset pulse.
  wwd_wd_type       wdState;
  logic [CNT_W-1:0] wdCnt;
  logic [CNT_W-1:0] mrCnt;

  // Device mode, handshake and data.
  wwd_mode_type     mode;
  logic             variantB;
  logic             measBusy;
  logic             measDone;
  logic             cmdInvalid;
  logic             drArm;
  logic [CNT_W-1:0] drCnt;
  logic [CNT_W-1:0] measCnt;
  logic [15:0]      measData;
  logic [7:0]       userReg;
  logic             errTrig;
  logic             errSupply;
  logic [2:0]       cause;

  // Bus slave state.
  logic        awHeld;
  logic [7:0]  awAddr;
  logic        wHeld;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        bValid;
  logic [1:0]  bResp;
  logic        rValid;
  logic [31:0] rData;
  logic [1:0]  rResp;

  // A pin change counts once the second and third stages agree.
  wire trigAgree = (trigSync[1] == trigSync[2]);
  wire wakeAgree = (wakeSync[1] == wakeSync[2]);
  wire trigFall  = trigAgree & ~trigSync[2] & trigLvl;
  wire debDone   = (debCnt == 8'(`WWD_DEB_CYC - 1));
  wire wakeFall  = (wakeLvl != wakeDeb) & debDone & wakeDeb;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      trigSync <= 3'h7;
      trigLvl  <= 1'b1;
      wakeSync <= 3'h7;
      wakeLvl  <= 1'b1;
    end else if (clkEn) begin
      trigSync <= {trigSync[1:0], wdTrigger};
      wakeSync <= {wakeSync[1:0], wakeUpN};
      if (trigAgree) trigLvl <= trigSync[2];
      if (wakeAgree) wakeLvl <= wakeSync[2];
    end
  end

  // wake debounce
  // The agreed level must hold for the full debounce time to count.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wakeDeb <= 1'b1;
      debCnt  <= 8'h00;
    end else if (clkEn) begin
      if (wakeLvl == wakeDeb) begin
        debCnt <= 8'h00;
      end else if (debDone) begin
        wakeDeb <= wakeLvl;
        debCnt  <= 8'h00;
      end else begin
        debCnt <= debCnt + 8'h01;
      end
    end
  end

  // Bus write decode; a write fires once address and data are both held.
  wire doWrite  = awHeld & wHeld & ~bValid;
  wire wrByte0  = doWrite & wStrb[0];
  wire wrCmd    = wrByte0 & (awAddr == `WWD_OFF_CMD);
  wire wrErr    = wrByte0 & (awAddr == `WWD_OFF_ERR);
  wire wrCause  = wrByte0 & (awAddr == `WWD_OFF_CAUSE);
  wire wrUser   = wrByte0 & (awAddr == `WWD_OFF_USER);
  wire wrMapped = (awAddr == `WWD_OFF_CMD) | (awAddr == `WWD_OFF_STATUS)
                | (awAddr == `WWD_OFF_ERR) | (awAddr == `WWD_OFF_CAUSE)
                | (awAddr == `WWD_OFF_DATA) | (awAddr == `WWD_OFF_USER);
  wire [3:0] cmdCode = wData[3:0];

  // Command decode.
  wire isNrm   = wrCmd & (cmdCode == CMD_NRM);
  wire isSlp   = wrCmd & ((cmdCode == CMD_SLP_A) | (cmdCode == CMD_SLP_B));
  wire isStby  = wrCmd & ((cmdCode == CMD_STBY_A) | (cmdCode == CMD_STBY_B));
  wire isCr    = wrCmd & (cmdCode == CMD_CR);
  wire isSm    = wrCmd & (cmdCode == CMD_SM);
  wire isRo    = wrCmd & (cmdCode == CMD_RO);
  wire isSmx   = wrCmd & (cmdCode == CMD_SMX);
  wire isVarB  = (cmdCode == CMD_SLP_B) | (cmdCode == CMD_STBY_B);
  wire inNrm   = (mode == MODE_NRM);
  wire inSlp   = (mode == MODE_SLP);
  wire canMeas = inNrm & dataReady & ~measBusy;

  wire toNrm     = (isNrm | wakeFall) & ~inNrm;
  wire toSlp     = isSlp & ~inSlp;
  wire toStby    = isStby & (mode != MODE_STBY);
  wire modeChg   = toNrm | toSlp | toStby;
  // read-out must precede the next cycle
  wire smOk      = isSm & canMeas & ~measDone;
  wire roOk      = isRo & canMeas & measDone;
  wire smxOk     = isSmx & canMeas & measDone;
  wire badCmd    = (wrCmd & ~isCr & ~isSlp & ~isStby & ~isNrm & ~smOk & ~roOk & ~smxOk)
                 | (isNrm & inNrm & ~wakeFall);
  wire leaveSlp  = inSlp & (toNrm | isCr);
  wire measEnd   = measBusy & (measCnt == '0);
  wire readOut   = roOk | smxOk;

  // Watchdog events.
  wire wdRun     = (wdState != WD_OFF);
  wire wdZero    = (wdCnt == '0);
  wire wdViol    = wdRun & trigFall & (wdState == WD_CLOSED);
  wire wdTout    = wdRun & ~trigFall & wdZero & (wdState != WD_CLOSED);
  wire wdFire    = wdViol | wdTout;

  // watchdog sequence
  // Only sleep entry and a return to normal or reinit from sleep touch the watchdog; standby and other reinits do not.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wdState <= WD_INIT;
      wdCnt   <= CNT_W'(INIT_CYC - 1);
    end else if (clkEn) begin
      if (toSlp) begin
        wdState <= WD_OFF;
      end else if (leaveSlp || wdFire) begin
        wdState <= WD_INIT;
        wdCnt   <= CNT_W'(INIT_CYC - 1);
      end else if (wdRun && trigFall) begin
        wdState <= WD_CLOSED;
        wdCnt   <= CNT_W'(CLOSED_CYC - 1);
      end else if (wdRun && wdZero) begin
        wdState <= WD_OPEN;
        wdCnt   <= CNT_W'(OPEN_CYC - 1);
      end else if (wdRun) begin
        wdCnt <= wdCnt - CNT_W'(1);
      end
    end
  end

  // master reset pulse
  // A new fault during a pulse restarts the full pulse time.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      masterResetN <= 1'b1;
      mrCnt        <= '0;
    end else if (clkEn) begin
      if (wdFire) begin
        masterResetN <= 1'b0;
        mrCnt        <= CNT_W'(MR_CYC - 1);
      end else if (!masterResetN) begin
        if (mrCnt == '0) masterResetN <= 1'b1;
        else mrCnt <= mrCnt - CNT_W'(1);
      end
    end
  end

  // Reset cause: write one to clear, a new cause in the same cycle wins.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cause <= `WWD_RST_CAUSE;
    end else if (clkEn) begin
      cause[`WWD_CAUSE_POR]  <= cause[`WWD_CAUSE_POR] & ~(wrCause & wData[0]);
      cause[`WWD_CAUSE_TOUT] <= wdTout | (cause[`WWD_CAUSE_TOUT] & ~(wrCause & wData[1]));
      cause[`WWD_CAUSE_VIOL] <= wdViol | (cause[`WWD_CAUSE_VIOL] & ~(wrCause & wData[2]));
    end
  end

  // error register
  // The supply bit follows the live fault one cycle late; trigger flag is sticky.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      errTrig   <= 1'b0;
      errSupply <= 1'b0;
    end else if (clkEn) begin
      errSupply <= supplyFault;
      errTrig   <= (inSlp & trigFall) | (errTrig & ~(wrErr & wData[`WWD_ERR_TRIG]));
    end
  end

  // mode, flags and user settings
  // Reinit returns to power-on values; mode changes keep data and settings.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode       <= MODE_NRM;
      variantB   <= 1'b0;
      cmdInvalid <= 1'b0;
      userReg    <= `WWD_RST_USER;
    end else if (clkEn) begin
      if (isCr) begin
        mode       <= MODE_NRM;
        variantB   <= 1'b0;
        cmdInvalid <= 1'b0;
        userReg    <= `WWD_RST_USER;
      end else begin
        cmdInvalid <= badCmd | (cmdInvalid & ~wrCmd);
        if (wrUser) userReg <= wData[7:0];
        if (toNrm) begin
          mode     <= MODE_NRM;
          variantB <= 1'b0;
        end else if (toSlp || toStby) begin
          mode     <= toSlp ? MODE_SLP : MODE_STBY;
          variantB <= isVarB;
        end
      end
    end
  end

  // measurement cycle and data
  // A combined read-out clears the results and starts the next cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      measBusy <= 1'b0;
      measDone <= 1'b0;
      measCnt  <= '0;
      measData <= `WWD_RST_DATA;
    end else if (clkEn) begin
      if (isCr) begin
        measBusy <= 1'b0;
        measDone <= 1'b0;
        measData <= `WWD_RST_DATA;
      end else if (modeChg) begin
        measBusy <= 1'b0;
      end else if (measEnd) begin
        measBusy <= 1'b0;
        measDone <= 1'b1;
        measData <= measSample;
      end else begin
        if (readOut) begin
          measDone <= 1'b0;
          measData <= `WWD_RST_DATA;
        end
        if (smOk || smxOk) begin
          measBusy <= 1'b1;
          measCnt  <= CNT_W'(MEAS_CYC - 1);
        end else if (measBusy) begin
          measCnt <= measCnt - CNT_W'(1);
        end
      end
    end
  end

  // data-ready
  // The line stays low in sleep and standby; a wake arms the matching delay.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dataReady <= 1'b0;
      drArm     <= 1'b1;
      drCnt     <= CNT_W'(START_CYC - 1);
    end else if (clkEn) begin
      if (isCr) begin
        dataReady <= 1'b0;
        drArm     <= 1'b1;
        drCnt     <= CNT_W'(START_CYC - 1);
      end else if (toNrm) begin
        dataReady <= 1'b0;
        drArm     <= 1'b1;
        drCnt     <= inSlp ? CNT_W'(WSLP_CYC - 1) : CNT_W'(WSTBY_CYC - 1);
      end else if (toSlp || toStby) begin
        dataReady <= 1'b0;
        drArm     <= 1'b0;
      end else if (measEnd) begin
        dataReady <= 1'b1;
      end else if (smOk || smxOk) begin
        dataReady <= 1'b0;
      end else if (drArm) begin
        if (drCnt == '0) begin
          dataReady <= 1'b1;
          drArm     <= 1'b0;
        end else begin
          drCnt <= drCnt - CNT_W'(1);
        end
      end
    end
  end

  // Status byte as software sees it.
  wire [7:0] statusByte = {cmdInvalid, 2'b00, measDone, measBusy, variantB, mode};
  wire [1:0] errByte    = {errSupply, errTrig};

  wire [7:0]  rdAddr = axiReq.araddr;
  wire        rdMap  = (rdAddr == `WWD_OFF_CMD) | (rdAddr == `WWD_OFF_STATUS)
                     | (rdAddr == `WWD_OFF_ERR) | (rdAddr == `WWD_OFF_CAUSE)
                     | (rdAddr == `WWD_OFF_DATA) | (rdAddr == `WWD_OFF_USER);
  wire [31:0] rdMux  =
    (rdAddr == `WWD_OFF_STATUS) ? {24'h000000, statusByte} :
    (rdAddr == `WWD_OFF_ERR)    ? {30'h0, errByte} :
    (rdAddr == `WWD_OFF_CAUSE)  ? {29'h0, cause} :
    (rdAddr == `WWD_OFF_DATA)   ? {16'h0000, measData} :
    (rdAddr == `WWD_OFF_USER)   ? {24'h000000, userReg} : 32'h00000000;

  // Write channels are held independently so either may arrive first.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld  <= 1'b0;
      wData  <= 32'h00000000;
      wStrb  <= 4'h0;
      bValid <= 1'b0;
      bResp  <= 2'h0;
    end else if (clkEn) begin
      if (axiReq.awvalid && !awHeld) begin
        awHeld <= 1'b1;
        awAddr <= axiReq.awaddr;
      end
      if (axiReq.wvalid && !wHeld) begin
        wHeld <= 1'b1;
        wData <= axiReq.wdata;
        wStrb <= axiReq.wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bValid <= 1'b1;
        bResp  <= wrMapped ? 2'h0 : 2'h2;
      end else if (bValid && axiReq.bready) begin
        bValid <= 1'b0;
      end
    end
  end

  // One read at a time; unmapped addresses answer with a slave error.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rValid <= 1'b0;
      rData  <= 32'h00000000;
      rResp  <= 2'h0;
    end else if (clkEn) begin
      if (axiReq.arvalid && !rValid) begin
        rValid <= 1'b1;
        rData  <= rdMux;
        rResp  <= rdMap ? 2'h0 : 2'h2;
      end else if (rValid && axiReq.rready) begin
        rValid <= 1'b0;
      end
    end
  end

  // Ready outputs are plain combinational terms of the held flags.
  assign axiRsp = '{
    awready: ~awHeld,
    wready:  ~wHeld,
    bresp:   bResp,
    bvalid:  bValid,
    arready: ~rValid,
    rdata:   rData,
    rresp:   rResp,
    rvalid:  rValid
  };

endmodule
`default_nettype wire

// [dv/wwd_control_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wwd_regs.svh"

// Watches the top ports and judges reset pulse, data-ready and window timing.
module wwd_control_checker
  import wwd_pkg::*;
#(
  parameter int unsigned INIT_CYC  = 40,
  parameter int unsigned MR_CYC    = 5,
  parameter int unsigned START_CYC = 10,
  parameter int unsigned MEAS_CYC  = 25
) (
  input wire logic            sys_clk,
  input wire logic            resetn,
  input wire wwd_axi_req_type axiReq,
  input wire wwd_axi_rsp_type axiRsp,
  input wire logic            wdTrigger,
  input wire logic            masterResetN,
  input wire logic            dataReady
);
  localparam int MEAS_LO = MEAS_CYC - 1;
  localparam int MEAS_HI = MEAS_CYC + 2;
  logic [15:0] sinceRst;
  logic [15:0] lowCnt;
  logic        trigSeen;
  logic        mrSeen;
  logic        cmdSeen;
  logic [7:0]  awLast;
  logic [3:0]  cmdLast;
  // Decode of the write that completes, from the address and data taken earlier.
  wire isCmd   = (awLast == `WWD_OFF_CMD) && (axiRsp.bresp == 2'b00);
  wire modeCmd = isCmd && (cmdLast >= 4'h2) && (cmdLast <= 4'h5);
  wire smCmd   = isCmd && (cmdLast == CMD_SM);
  wire crCmd   = isCmd && (cmdLast == CMD_CR);

  // Cycle counts and sticky flags; they restart with reset so that a second reset is judged alike.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sinceRst <= 16'h0000;
      lowCnt   <= 16'h0000;
      trigSeen <= 1'b0;
      mrSeen   <= 1'b0;
      cmdSeen  <= 1'b0;
      awLast   <= 8'h00;
      cmdLast  <= 4'h0;
    end else begin
      sinceRst <= sinceRst + 16'h0001;
      lowCnt   <= masterResetN ? 16'h0000 : lowCnt + 16'h0001;
      trigSeen <= trigSeen | ~wdTrigger;
      mrSeen   <= mrSeen | ~masterResetN;
      cmdSeen  <= cmdSeen | axiRsp.bvalid;
      if (axiReq.awvalid && axiRsp.awready) awLast <= axiReq.awaddr;
      if (axiReq.wvalid && axiRsp.wready) cmdLast <= axiReq.wdata[3:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_mr_width; $rose(masterResetN) |-> lowCnt == MR_CYC; endproperty
  a_mr_width: assert property (p_mr_width) else $error("reset pulse width wrong");
  property p_mr_bound; !masterResetN |-> lowCnt < MR_CYC; endproperty
  a_mr_bound: assert property (p_mr_bound) else $error("reset pulse too long");
  property p_dr_start; sinceRst < START_CYC - 1 |-> !dataReady; endproperty
  a_dr_start: assert property (p_dr_start) else $error("data ready too early");
  property p_mr_init; sinceRst < INIT_CYC - 1 |-> masterResetN; endproperty
  a_mr_init: assert property (p_mr_init) else $error("host reset too early");
  property p_timeout;
    sinceRst == INIT_CYC + 2 && !trigSeen && !cmdSeen |-> mrSeen;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no timeout after first window");
  property p_mode_dr; $rose(axiRsp.bvalid) && modeCmd |-> !dataReady; endproperty
  a_mode_dr: assert property (p_mode_dr) else $error("data ready kept on mode change");
  property p_meas;
    $rose(axiRsp.bvalid) && smCmd && $past(dataReady) && !dataReady
      |-> ##[MEAS_LO:MEAS_HI] dataReady;
  endproperty
  a_meas: assert property (p_meas) else $error("measurement end not flagged");
  property p_dr_keep; $fell(masterResetN) |-> $stable(dataReady); endproperty
  a_dr_keep: assert property (p_dr_keep) else $error("timeout moved data ready");
  property p_reinit_dr; $rose(axiRsp.bvalid) && crCmd |-> !dataReady [*8]; endproperty
  a_reinit_dr: assert property (p_reinit_dr) else $error("reinit raised data ready early");
endmodule
`default_nettype wire

// [dv/wwd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Host side: feeds the watchdog on a fixed period, kicks on demand, drives the wake pin.
module wwd_host_model #(
  parameter int unsigned FEED_CYC = 30
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       feed,
  input  wire logic       kick,
  input  wire logic       wakeReq,
  input  wire logic [7:0] wakeLen,
  output var  logic       wdTrigger,
  output var  logic       wakeUpN
);
  logic [7:0] feedCnt;
  logic [7:0] trigCnt;
  logic [7:0] wakeCnt;
  // Pins idle high; a restart is a four-cycle low pulse so the input filter agrees on it.
  assign wdTrigger = (trigCnt == 8'h00);
  assign wakeUpN   = (wakeCnt == 8'h00);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      feedCnt <= 8'h00;
      trigCnt <= 8'h00;
      wakeCnt <= 8'h00;
    end else begin
      feedCnt <= (!feed || feedCnt == FEED_CYC[7:0]) ? 8'h00 : feedCnt + 8'h01;
      if (kick || (feed && feedCnt == FEED_CYC[7:0])) begin
        trigCnt <= 8'h04;
      end else if (trigCnt != 8'h00) begin
        trigCnt <= trigCnt - 8'h01;
      end
      if (wakeReq) begin
        wakeCnt <= wakeLen;
      end else if (wakeCnt != 8'h00) begin
        wakeCnt <= wakeCnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/wwd_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wwd_regs.svh"

module wwd_control_tb_top
  import wwd_pkg::*;
;
  localparam int unsigned INIT_CYC  = 40;
  localparam int unsigned MR_CYC    = 5;
  localparam int unsigned START_CYC = 10;
  localparam int unsigned MEAS_CYC  = 25;
  localparam logic [31:0] ALL       = 32'hFFFFFFFF;
  logic            sys_clk     = 1'b0;
  logic            resetn      = 1'b0;
  logic            clkEn       = 1'b1;
  logic            feed        = 1'b0;
  logic            kick        = 1'b0;
  logic            wakeReq     = 1'b0;
  logic            supplyFault = 1'b0;
  logic [7:0]      wakeLen     = 8'h00;
  logic [15:0]     measSample  = 16'hA5C3;
  wwd_axi_req_type axiReq      = '0;
  wwd_axi_rsp_type axiRsp;
  logic            wdTrigger;
  logic            wakeUpN;
  logic            masterResetN;
  logic            dataReady;
  logic [31:0]     rdata;
  logic [1:0]      resp;
  int              failures    = 0;
  int              checks_done = 0;
  int              cyc         = 0;
  int              t0;
  bit              hit;

  // Short windows keep the run brief; every expectation derives from these values.
  wwd_control #(.INIT_CYC(INIT_CYC), .CLOSED_CYC(20), .OPEN_CYC(30), .MR_CYC(MR_CYC),
    .START_CYC(START_CYC), .WSLP_CYC(8), .WSTBY_CYC(6), .MEAS_CYC(MEAS_CYC)) wwd_control_inst (
    .sys_clk, .resetn, .clkEn, .axiReq, .axiRsp, .wdTrigger, .wakeUpN, .supplyFault,
    .measSample, .masterResetN, .dataReady);
  wwd_host_model wwd_host_model_inst (
    .sys_clk, .resetn, .feed, .kick, .wakeReq, .wakeLen, .wdTrigger, .wakeUpN);

  // Clock and a cycle ceiling that cuts a hang short.
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, each dropped once taken, bready held.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && n < 100);
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    if (n >= 100) chk(32'h1, 32'h0);
  endtask

  // Bus read: rready held until the answer is sampled.
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && n < 100);
    rdata = axiRsp.rdata;
    resp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    if (n >= 100) chk(32'h1, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdata & m, e);
  endtask

  task automatic cmd(input logic [3:0] c);
    wr(`WWD_OFF_CMD, {28'h0, c});
  endtask

  // Waits for data-ready (mr=0) or host reset (mr=1) to reach a level.
  task automatic waitFor(input bit mr, input logic v, input int lim, output bit h);
    h = 1'b0;
    repeat (lim) begin
      @(posedge sys_clk);
      if ((mr ? masterResetN : dataReady) === v) begin
        h = 1'b1;
        break;
      end
    end
  endtask

  task automatic pulse(input bit wake, input logic [7:0] n);
    wakeLen <= n;
    if (wake) wakeReq <= 1'b1;
    else kick <= 1'b1;
    @(posedge sys_clk);
    wakeReq <= 1'b0;
    kick <= 1'b0;
  endtask

  // Main sequence: reset values, windows, measurement, modes, second reset.
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(`WWD_OFF_USER, ALL, 32'h02);
    rdc(`WWD_OFF_STATUS, ALL, 32'h00);
    rdc(`WWD_OFF_ERR, ALL, 32'h00);
    rdc(`WWD_OFF_DATA, ALL, 32'h00);
    rdc(`WWD_OFF_CAUSE, ALL, 32'h01);
    rd(8'h18);
    chk({30'h0, resp}, 32'h2);
    chk({31'h0, masterResetN}, 32'h1);
    waitFor(0, 1'b1, 40, hit);
    chk({31'h0, hit}, 32'h1);
    waitFor(1, 1'b0, 80, hit);
    t0 = cyc;
    wr(`WWD_OFF_USER, 32'h5A);
    cmd(CMD_STBY_A);
    cmd(CMD_CR);
    waitFor(1, 1'b0, 80, hit);
    chk({31'h0, hit && cyc - t0 >= INIT_CYC - 2 && cyc - t0 <= INIT_CYC + MR_CYC + 2}, 1);
    rdc(`WWD_OFF_USER, ALL, 32'h02);
    rdc(`WWD_OFF_CAUSE, ALL, 32'h03);
    wr(`WWD_OFF_CAUSE, 32'h07);
    pulse(0, 8'h00);
    repeat (12) @(posedge sys_clk);
    pulse(0, 8'h00);
    waitFor(1, 1'b0, 20, hit);
    feed <= 1'b1;
    chk({31'h0, hit}, 32'h1);
    rdc(`WWD_OFF_CAUSE, ALL, 32'h04);
    // The fault pulse must end first, or its low level counts as a new reset.
    waitFor(1, 1'b1, 20, hit);
    waitFor(1, 1'b0, 150, hit);
    chk({31'h0, hit}, 32'h0);
    feed <= 1'b0;
    waitFor(1, 1'b0, 80, hit);
    feed <= 1'b1;
    chk({31'h0, hit}, 32'h1);
    rdc(`WWD_OFF_CAUSE, 32'h02, 32'h02);
    cmd(CMD_SM);
    waitFor(0, 1'b1, 40, hit);
    rdc(`WWD_OFF_DATA, ALL, 32'hA5C3);
    rdc(`WWD_OFF_STATUS, 32'h18, 32'h10);
    cmd(CMD_RO);
    rdc(`WWD_OFF_DATA, ALL, 32'h00);
    cmd(CMD_SM);
    waitFor(0, 1'b1, 40, hit);
    measSample <= 16'h3C5A;
    cmd(CMD_SMX);
    rdc(`WWD_OFF_DATA, ALL, 32'h00);
    rdc(`WWD_OFF_STATUS, 32'h18, 32'h08);
    waitFor(0, 1'b1, 40, hit);
    rdc(`WWD_OFF_DATA, ALL, 32'h3C5A);
    for (int i = 0; i < 2; i++) begin
      cmd(4'(CMD_STBY_A + i));
      rdc(`WWD_OFF_STATUS, 32'h07, 32'(1 + 4 * i));
      pulse(1, 8'd10);
      waitFor(0, 1'b1, 80, hit);
      chk({31'h0, hit}, 32'h0);
      pulse(1, 8'd80);
      waitFor(0, 1'b1, 120, hit);
      chk({31'h0, hit}, 32'h1);
      rdc(`WWD_OFF_STATUS, 32'h03, 32'h00);
      // Let the long wake low end and settle, so the next spike starts from idle.
      repeat (80) @(posedge sys_clk);
    end
    cmd(CMD_NRM);
    rdc(`WWD_OFF_STATUS, 32'h80, 32'h80);
    feed <= 1'b0;
    cmd(CMD_SLP_B);
    rdc(`WWD_OFF_STATUS, 32'h07, 32'h06);
    waitFor(1, 1'b0, 120, hit);
    chk({31'h0, hit}, 32'h0);
    pulse(0, 8'h00);
    repeat (8) @(posedge sys_clk);
    rdc(`WWD_OFF_ERR, 32'h01, 32'h01);
    wr(`WWD_OFF_ERR, 32'h01);
    rdc(`WWD_OFF_ERR, 32'h01, 32'h00);
    supplyFault <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(`WWD_OFF_ERR, 32'h02, 32'h02);
    supplyFault <= 1'b0;
    cmd(CMD_NRM);
    waitFor(0, 1'b1, 20, hit);
    chk({31'h0, hit}, 32'h1);
    waitFor(1, 1'b0, 60, hit);
    feed <= 1'b1;
    chk({31'h0, hit}, 32'h1);
    cmd(CMD_SLP_A);
    pulse(1, 8'd80);
    waitFor(0, 1'b1, 120, hit);
    rdc(`WWD_OFF_STATUS, 32'h03, 32'h00);
    // Frozen clock enable: without restarts the watchdog must still not expire.
    feed <= 1'b0;
    clkEn <= 1'b0;
    waitFor(1, 1'b0, 60, hit);
    chk({31'h0, hit}, 32'h0);
    clkEn <= 1'b1;
    wr(8'h18, 32'h01);
    chk({30'h0, resp}, 32'h2);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(`WWD_OFF_CAUSE, ALL, 32'h01);
    results();
  end
endmodule

bind wwd_control wwd_control_checker #(.INIT_CYC(INIT_CYC), .MR_CYC(MR_CYC),
  .START_CYC(START_CYC), .MEAS_CYC(MEAS_CYC)) wwd_control_checker_inst (
  .sys_clk, .resetn, .axiReq, .axiRsp, .wdTrigger, .masterResetN, .dataReady);
`default_nettype wire
